// ### design/bbd_core.sv
`timescale 1ns/1ps
`default_nettype none
module bbd_core #(
    parameter int MC_CLKS = bbd_pkg::MC_CLKS_DEF // Clocks per machine cycle, at least 12.
) (
    input wire logic i_ref_clk, // 250 MHz clock.
    input wire logic i_rst, // Synchronous reset, active high.
    input wire logic [7:0] i_code_data, // Program byte at o_code_addr.
    input wire logic [7:0] i_acc, // Accumulator of the core.
    input wire logic [15:0] i_data_pointer_16, // Data pointer of the core.
    output logic [15:0] o_code_addr, // Program fetch address.
    output logic o_code_rd, // Fetch strobe.
    output logic [15:0] o_pc, // Program counter.
    output logic o_carry, // Carry flag.
    output logic o_retire, // Instruction finished.
    output logic o_irq_return, // Interrupt return finished.
    output logic o_unhandled // Opcode outside these groups.
);
    localparam int DIV_W = $clog2(MC_CLKS);

    // ==========================================================
    // State
    bbd_pkg::bbd_state_type st_q;
    bbd_pkg::bbd_class_type cls_q;
    bbd_pkg::bbd_class_type dec_cls;
    logic [1:0] len_q, dec_len, cyc_q, dec_cyc, idx_q, used_q, cur_len;
    logic [7:0] op_q, b2_q, b3_q, opa_q, opb_q, sp_q, ret_hi_q, dec_in;
    logic [15:0] pc_q;
    logic carry_q, started_q;
    logic [DIV_W-1:0] div_q;
    logic tick, done;
    logic ram_we_q;
    logic [7:0] ram_wa_q, ram_wd_q, ram_ra, ram_rd;
    logic need_a, need_b, bit_val, taken, wa_en, bit_wr, newbit, is_call, is_ret;
    logic [7:0] addr_a, addr_b, rel, wa_d, wd_d;
    logic [15:0] pc_d;
    logic carry_d;

    // ==========================================================
    // Machine-cycle divider
    assign tick = (div_q == '0);
    assign done = (used_q + 2'h1) >= cyc_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst || div_q == DIV_W'(MC_CLKS - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // ==========================================================
    // Decode and operand addressing
    assign dec_in = (st_q == bbd_pkg::S_CAPT && idx_q == 2'h0) ? i_code_data : op_q;
    assign cur_len = (idx_q == 2'h0) ? dec_len : len_q;

    bbd_decode u_dec (
        .i_opcode(dec_in),
        .o_class(dec_cls),
        .o_len(dec_len),
        .o_cycles(dec_cyc)
    );

    assign is_call = (cls_q == bbd_pkg::CL_SHORT_CALL) || (cls_q == bbd_pkg::CL_LONG_CALL);
    assign is_ret = (cls_q == bbd_pkg::CL_SUB_RET) || (cls_q == bbd_pkg::CL_INT_RET);
    assign need_b = is_ret || (cls_q == bbd_pkg::CL_CMP_IND);
    assign bit_val = opa_q[b2_q[2:0]];
    // Only the bank 0 registers are reached; bank switching lives elsewhere.
    assign addr_b = (cls_q == bbd_pkg::CL_CMP_IND) ? opa_q : sp_q - 8'h01;
    assign ram_ra = (st_q == bbd_pkg::S_RDB) ? addr_b : addr_a;
    assign rel = (len_q == 2'h3) ? b3_q : b2_q;
    assign wa_d = is_call ? sp_q + 8'h01 : addr_a;

    always_comb begin
        need_a = 1'b1;
        case (cls_q)
            bbd_pkg::CL_CMP_DIR, bbd_pkg::CL_DEC_DIR: addr_a = b2_q;
            bbd_pkg::CL_CMP_REG, bbd_pkg::CL_DEC_REG: addr_a = {5'h00, op_q[2:0]};
            bbd_pkg::CL_CMP_IND: addr_a = {7'h00, op_q[0]};
            bbd_pkg::CL_SUB_RET, bbd_pkg::CL_INT_RET: addr_a = sp_q;
            default: addr_a = bbd_pkg::bit_byte(b2_q);
        endcase
        case (cls_q)
            bbd_pkg::CL_NOP, bbd_pkg::CL_CLR_C, bbd_pkg::CL_SET_C, bbd_pkg::CL_INV_C,
            bbd_pkg::CL_SHORT_CALL, bbd_pkg::CL_SHORT_JUMP, bbd_pkg::CL_LONG_CALL,
            bbd_pkg::CL_LONG_JUMP, bbd_pkg::CL_REL_JUMP, bbd_pkg::CL_IND_JUMP,
            bbd_pkg::CL_BR_ACC_Z, bbd_pkg::CL_BR_ACC_NZ, bbd_pkg::CL_BR_C1, bbd_pkg::CL_BR_C0,
            bbd_pkg::CL_CMP_IMM, bbd_pkg::CL_OTHER: need_a = 1'b0;
            default: need_a = 1'b1;
        endcase
    end

    // ==========================================================
    // Execution
    always_comb begin
        pc_d = pc_q;
        carry_d = carry_q;
        taken = 1'b0;
        wa_en = 1'b0;
        bit_wr = 1'b0;
        newbit = 1'b0;
        wd_d = opa_q;
        case (cls_q)
            bbd_pkg::CL_CLR_C: carry_d = 1'b0; // RULE_23
            bbd_pkg::CL_SET_C: carry_d = 1'b1; // RULE_23
            bbd_pkg::CL_INV_C: carry_d = ~carry_q; // RULE_23
            bbd_pkg::CL_AND_BIT: carry_d = carry_q & bit_val; // RULE_01
            bbd_pkg::CL_ANDN_BIT: carry_d = carry_q & ~bit_val; // RULE_02
            bbd_pkg::CL_OR_BIT: carry_d = carry_q | bit_val; // RULE_03
            bbd_pkg::CL_ORN_BIT: carry_d = carry_q | ~bit_val; // RULE_04
            bbd_pkg::CL_MOV_C_BIT: carry_d = bit_val; // RULE_05
            bbd_pkg::CL_CLR_BIT: bit_wr = 1'b1; // RULE_23
            bbd_pkg::CL_SET_BIT: begin
                bit_wr = 1'b1;
                newbit = 1'b1;
            end
            bbd_pkg::CL_INV_BIT: begin
                bit_wr = 1'b1;
                newbit = ~bit_val;
            end
            bbd_pkg::CL_MOV_BIT_C: begin
                bit_wr = 1'b1; // RULE_06
                newbit = carry_q;
            end
            bbd_pkg::CL_SHORT_CALL, bbd_pkg::CL_SHORT_JUMP: pc_d = {pc_q[15:11], op_q[7:5], b2_q}; // RULE_21 RULE_24
            bbd_pkg::CL_LONG_CALL, bbd_pkg::CL_LONG_JUMP: pc_d = {b2_q, b3_q}; // RULE_22
            bbd_pkg::CL_SUB_RET, bbd_pkg::CL_INT_RET: pc_d = {opa_q, opb_q}; // RULE_25
            bbd_pkg::CL_REL_JUMP: taken = 1'b1;
            bbd_pkg::CL_IND_JUMP: pc_d = i_data_pointer_16 + {8'h00, i_acc}; // RULE_07
            bbd_pkg::CL_BR_ACC_Z: taken = (i_acc == 8'h00);
            bbd_pkg::CL_BR_ACC_NZ: taken = (i_acc != 8'h00); // RULE_08
            bbd_pkg::CL_BR_C1: taken = carry_q; // RULE_09
            bbd_pkg::CL_BR_C0: taken = ~carry_q; // RULE_10
            bbd_pkg::CL_BR_BIT1: taken = bit_val; // RULE_11
            bbd_pkg::CL_BR_BIT0: taken = ~bit_val; // RULE_12
            bbd_pkg::CL_BR_BIT1_CLR: begin
                taken = bit_val; // RULE_13
                bit_wr = bit_val;
            end
            bbd_pkg::CL_CMP_DIR: taken = (i_acc != opa_q); // RULE_14
            bbd_pkg::CL_CMP_IMM: taken = (i_acc != b2_q); // RULE_15
            bbd_pkg::CL_CMP_REG: taken = (opa_q != b2_q); // RULE_16
            bbd_pkg::CL_CMP_IND: taken = (opb_q != b2_q); // RULE_17
            bbd_pkg::CL_DEC_REG, bbd_pkg::CL_DEC_DIR: begin
                wa_en = 1'b1; // RULE_18 RULE_19
                wd_d = opa_q - 8'h01;
                taken = (opa_q != 8'h01);
            end
            default: pc_d = pc_q;
        endcase
        if (bit_wr) begin
            wa_en = 1'b1;
            wd_d[b2_q[2:0]] = newbit;
        end
        if (is_call) begin
            wa_en = 1'b1; // RULE_25
            wd_d = pc_q[7:0];
        end
        if (taken) begin
            pc_d = bbd_pkg::rel_target(pc_q, rel); // RULE_20
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_q <= bbd_pkg::S_WAIT;
            idx_q <= 2'h0;
            used_q <= 2'h0;
            started_q <= 1'b0;
            cls_q <= bbd_pkg::CL_NOP;
            len_q <= 2'h1;
            cyc_q <= 2'h1;
            op_q <= 8'h00;
            b2_q <= 8'h00;
            b3_q <= 8'h00;
            opa_q <= 8'h00;
            opb_q <= 8'h00;
        end else begin
            case (st_q)
                bbd_pkg::S_WAIT: begin
                    if (tick && done) begin
                        st_q <= bbd_pkg::S_FETCH;
                        used_q <= 2'h0;
                        idx_q <= 2'h0;
                        started_q <= 1'b1;
                    end else if (tick) begin
                        used_q <= used_q + 2'h1;
                    end
                end
                bbd_pkg::S_FETCH: st_q <= bbd_pkg::S_CAPT;
                bbd_pkg::S_CAPT: begin
                    idx_q <= idx_q + 2'h1;
                    if (idx_q == 2'h0) begin
                        op_q <= i_code_data;
                        cls_q <= dec_cls;
                        len_q <= dec_len;
                        cyc_q <= dec_cyc;
                    end else if (idx_q == 2'h1) begin
                        b2_q <= i_code_data;
                    end else begin
                        b3_q <= i_code_data;
                    end
                    st_q <= (idx_q + 2'h1 < cur_len) ? bbd_pkg::S_FETCH : bbd_pkg::S_RDA;
                end
                bbd_pkg::S_RDA: st_q <= need_a ? bbd_pkg::S_CAPA : bbd_pkg::S_EXEC;
                bbd_pkg::S_CAPA: begin
                    opa_q <= ram_rd;
                    st_q <= need_b ? bbd_pkg::S_RDB : bbd_pkg::S_EXEC;
                end
                bbd_pkg::S_RDB: st_q <= bbd_pkg::S_CAPB;
                bbd_pkg::S_CAPB: begin
                    opb_q <= ram_rd;
                    st_q <= bbd_pkg::S_EXEC;
                end
                bbd_pkg::S_EXEC: st_q <= is_call ? bbd_pkg::S_WRB : bbd_pkg::S_WAIT;
                bbd_pkg::S_WRB: st_q <= bbd_pkg::S_WAIT;
                default: st_q <= bbd_pkg::S_WAIT;
            endcase
        end
    end

    // ==========================================================
    // Program counter, carry and stack pointer
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pc_q <= 16'h0000;
        end else if (st_q == bbd_pkg::S_CAPT) begin
            pc_q <= pc_q + 16'h0001;
        end else if (st_q == bbd_pkg::S_EXEC) begin
            pc_q <= pc_d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            carry_q <= 1'b0;
        end else if (st_q == bbd_pkg::S_EXEC) begin
            carry_q <= carry_d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sp_q <= bbd_pkg::SP_RESET;
        end else if (st_q == bbd_pkg::S_EXEC && is_call) begin
            sp_q <= sp_q + 8'h02; // RULE_25
        end else if (st_q == bbd_pkg::S_EXEC && is_ret) begin
            sp_q <= sp_q - 8'h02; // RULE_25
        end
    end

    // ==========================================================
    // Data memory writes
    // A call writes the low return byte from the execute step and the high byte one clock later.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ram_we_q <= 1'b0;
            ram_wa_q <= 8'h00;
            ram_wd_q <= 8'h00;
            ret_hi_q <= 8'h00;
        end else if (st_q == bbd_pkg::S_EXEC) begin
            ram_we_q <= wa_en;
            ram_wa_q <= wa_d;
            ram_wd_q <= wd_d;
            ret_hi_q <= pc_q[15:8];
        end else if (st_q == bbd_pkg::S_WRB) begin
            ram_we_q <= 1'b1;
            ram_wa_q <= sp_q;
            ram_wd_q <= ret_hi_q;
        end else begin
            ram_we_q <= 1'b0;
        end
    end

    bbd_ram #(
        .AW(8),
        .DW(8)
    ) u_ram (
        .i_ref_clk(i_ref_clk),
        .i_we(ram_we_q),
        .i_waddr(ram_wa_q),
        .i_wdata(ram_wd_q),
        .i_raddr(ram_ra),
        .o_rdata(ram_rd)
    );

    // ==========================================================
    // Outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_code_addr <= 16'h0000;
            o_code_rd <= 1'b0;
            o_retire <= 1'b0;
            o_irq_return <= 1'b0;
            o_unhandled <= 1'b0;
        end else begin
            o_code_addr <= (st_q == bbd_pkg::S_FETCH) ? pc_q : o_code_addr;
            o_code_rd <= (st_q == bbd_pkg::S_FETCH);
            o_retire <= (st_q == bbd_pkg::S_WAIT) && tick && done && started_q;
            o_irq_return <= (st_q == bbd_pkg::S_EXEC) && (cls_q == bbd_pkg::CL_INT_RET);
            o_unhandled <= (st_q == bbd_pkg::S_EXEC) && (cls_q == bbd_pkg::CL_OTHER);
        end
    end

    assign o_pc = pc_q;
    assign o_carry = carry_q;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    logic ex;
    assign ex = (st_q == bbd_pkg::S_EXEC);

    sequence s_fetch;
        ##1 (st_q == bbd_pkg::S_CAPT && o_code_rd && o_code_addr == $past(pc_q));
    endsequence

    sequence s_push;
        ram_we_q && ram_wa_q == $past(sp_q) + 8'h01 ##1 ram_we_q && ram_wa_q == $past(sp_q, 2) + 8'h02;
    endsequence

    a_fetch_strobe: assert property ( // RULE_22
        st_q == bbd_pkg::S_FETCH |-> s_fetch) else $error("fetch strobe wrong");
    a_and_carry: assert property ( // RULE_01
        ex && cls_q == bbd_pkg::CL_AND_BIT |=> carry_q == ($past(carry_q) & $past(bit_val)))
        else $error("carry and wrong");
    a_andn_carry: assert property ( // RULE_02
        ex && op_q == 8'hB0 |=> carry_q == ($past(carry_q) & ~$past(bit_val))) else $error("carry and-not wrong");
    a_orn_carry: assert property ( // RULE_04
        ex && op_q == 8'hA0 |=> carry_q == ($past(carry_q) | ~$past(bit_val))) else $error("carry or-not wrong");
    a_move_bit: assert property ( // RULE_05
        ex && op_q == 8'hA2 |-> cyc_q == 2'h1 && len_q == 2'h2 ##1 carry_q == $past(bit_val))
        else $error("bit to carry wrong");
    a_store_bit: assert property ( // RULE_06
        ex && op_q == 8'h92 |-> cyc_q == 2'h2 ##1 ram_we_q && ram_wa_q == bbd_pkg::bit_byte(b2_q))
        else $error("carry to bit wrong");
    a_ind_jump: assert property ( // RULE_07
        ex && op_q == 8'h73 |=> pc_q == $past(i_data_pointer_16 + {8'h00, i_acc})) else $error("indirect jump wrong");
    a_acc_branch: assert property ( // RULE_08
        ex && op_q == 8'h70 && i_acc != 8'h00 |=> pc_q == $past(bbd_pkg::rel_target(pc_q, b2_q)))
        else $error("nonzero branch wrong");
    a_clear_bit: assert property ( // RULE_13
        ex && op_q == 8'h10 && bit_val |=> ram_we_q && !ram_wd_q[b2_q[2:0]]) else $error("bit not cleared");
    a_dec_write: assert property ( // RULE_18
        ex && cls_q == bbd_pkg::CL_DEC_REG |=> ram_wd_q == $past(opa_q) - 8'h01) else $error("decrement wrong");
    a_page_keep: assert property ( // RULE_21
        ex && op_q[3:0] == 4'h1 |=> pc_q[15:11] == $past(pc_q[15:11]) && pc_q[10:8] == $past(op_q[7:5]))
        else $error("page target wrong");
    a_call_push: assert property ( // RULE_25
        ex && is_call |=> s_push) else $error("call push wrong");
endmodule // bbd_core
`default_nettype wire

// ### design/bbd_pkg.sv
// What this block does
// RULE_01: Opcode 82 ANDs addressed bit into carry.
// RULE_02: Opcode B0 ANDs inverted bit into carry.
// RULE_03: Opcode 72 ORs addressed bit into carry.
// RULE_04: Opcode A0 ORs inverted bit into carry.
// RULE_05: Opcode A2 copies bit to carry, one cycle.
// RULE_06: Opcode 92 writes carry to bit, two cycles.
// RULE_07: Opcode 73 jumps to accumulator plus pointer.
// RULE_08: Opcode 70 branches when accumulator nonzero.
// RULE_09: Opcode 40 branches when carry is one.
// RULE_10: Opcode 50 branches when carry is zero.
// RULE_11: Opcode 20 branches when bit is one.
// RULE_12: Opcode 30 branches when bit is zero.
// RULE_13: Opcode 10 branches and clears set bit.
// RULE_14: Opcode B5 compares direct byte, branches unequal.
// RULE_15: Opcode B4 compares immediate, branches unequal.
// RULE_16: Opcodes B8-BF compare register with immediate.
// RULE_17: Opcodes B6-B7 compare indirect byte with immediate.
// RULE_18: Opcodes D8-DF decrement register, branch nonzero.
// RULE_19: Opcode D5 decrements direct byte, branch nonzero.
// RULE_20: Relative offset is signed, from next instruction.
// RULE_21: Short targets stay in current 2 KB page.
// RULE_22: Long targets reach whole 64 KB space.
// RULE_23: Carry and bit set/clear/invert take one cycle.
// RULE_24: Short opcodes hold target bits 10 to 8.
// RULE_25: Calls push return address; returns pop it.
`default_nettype none
package bbd_pkg;
    // ==========================================================
    // Constants
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam int MC_CLKS_DEF = 16;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;

    // ==========================================================
    // Types
    typedef enum logic [5:0] {
        CL_NOP, CL_CLR_C, CL_SET_C, CL_INV_C, CL_CLR_BIT, CL_SET_BIT,
        CL_INV_BIT, CL_AND_BIT, CL_ANDN_BIT, CL_OR_BIT, CL_ORN_BIT,
        CL_MOV_C_BIT, CL_MOV_BIT_C, CL_SHORT_CALL, CL_SHORT_JUMP,
        CL_LONG_CALL, CL_LONG_JUMP, CL_SUB_RET, CL_INT_RET, CL_REL_JUMP,
        CL_IND_JUMP, CL_BR_ACC_Z, CL_BR_ACC_NZ, CL_BR_C1, CL_BR_C0,
        CL_BR_BIT1, CL_BR_BIT0, CL_BR_BIT1_CLR, CL_CMP_DIR, CL_CMP_IMM,
        CL_CMP_REG, CL_CMP_IND, CL_DEC_REG, CL_DEC_DIR, CL_OTHER
    } bbd_class_type;

    typedef enum logic [8:0] {
        S_WAIT = 9'h001,
        S_FETCH = 9'h002,
        S_CAPT = 9'h004,
        S_RDA = 9'h008,
        S_CAPA = 9'h010,
        S_RDB = 9'h020,
        S_CAPB = 9'h040,
        S_EXEC = 9'h080,
        S_WRB = 9'h100
    } bbd_state_type;

    // ==========================================================
    // Functions
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        if (b[7]) begin
            return {b[7:3], 3'h0};
        end
        return BIT_RAM_BASE + {4'h0, b[6:3]};
    endfunction

    function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] r);
        return pc + {{8{r[7]}}, r};
    endfunction
endpackage
`default_nettype wire

// ### design/bbd_ram.sv
`timescale 1ns/1ps
`default_nettype none
module bbd_ram #(
    parameter int AW = 8, // Address width.
    parameter int DW = 8 // Data width.
) (
    input wire logic i_ref_clk, // Clock.
    input wire logic i_we, // Write enable.
    input wire logic [AW-1:0] i_waddr, // Write address.
    input wire logic [DW-1:0] i_wdata, // Write data.
    input wire logic [AW-1:0] i_raddr, // Read address.
    output logic [DW-1:0] o_rdata // Registered read data.
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule // bbd_ram
`default_nettype wire

// ### design/bbd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bbd_decode (
    input wire logic [7:0] i_opcode, // Opcode byte.
    output var bbd_pkg::bbd_class_type o_class, // Operation class.
    output logic [1:0] o_len, // Bytes in instruction.
    output logic [1:0] o_cycles // Machine cycles.
);
    logic [9:0] d;

    function automatic logic [9:0] ent(input bbd_pkg::bbd_class_type c, input logic [1:0] l,
                                       input logic [1:0] n);
        return {c, l, n};
    endfunction

    always_comb begin
        d = ent(bbd_pkg::CL_OTHER, 2'h1, 2'h1);
        case (i_opcode)
            8'h00: d = ent(bbd_pkg::CL_NOP, 2'h1, 2'h1);
            8'hC3: d = ent(bbd_pkg::CL_CLR_C, 2'h1, 2'h1); // RULE_23
            8'hD3: d = ent(bbd_pkg::CL_SET_C, 2'h1, 2'h1); // RULE_23
            8'hB3: d = ent(bbd_pkg::CL_INV_C, 2'h1, 2'h1); // RULE_23
            8'hC2: d = ent(bbd_pkg::CL_CLR_BIT, 2'h2, 2'h1); // RULE_23
            8'hD2: d = ent(bbd_pkg::CL_SET_BIT, 2'h2, 2'h1); // RULE_23
            8'hB2: d = ent(bbd_pkg::CL_INV_BIT, 2'h2, 2'h1); // RULE_23
            8'h82: d = ent(bbd_pkg::CL_AND_BIT, 2'h2, 2'h2); // RULE_01
            8'hB0: d = ent(bbd_pkg::CL_ANDN_BIT, 2'h2, 2'h2); // RULE_02
            8'h72: d = ent(bbd_pkg::CL_OR_BIT, 2'h2, 2'h2); // RULE_03
            8'hA0: d = ent(bbd_pkg::CL_ORN_BIT, 2'h2, 2'h2); // RULE_04
            8'hA2: d = ent(bbd_pkg::CL_MOV_C_BIT, 2'h2, 2'h1); // RULE_05
            8'h92: d = ent(bbd_pkg::CL_MOV_BIT_C, 2'h2, 2'h2); // RULE_06
            8'h12: d = ent(bbd_pkg::CL_LONG_CALL, 2'h3, 2'h2); // RULE_22
            8'h02: d = ent(bbd_pkg::CL_LONG_JUMP, 2'h3, 2'h2); // RULE_22
            8'h22: d = ent(bbd_pkg::CL_SUB_RET, 2'h1, 2'h2); // RULE_25
            8'h32: d = ent(bbd_pkg::CL_INT_RET, 2'h1, 2'h2); // RULE_25
            8'h80: d = ent(bbd_pkg::CL_REL_JUMP, 2'h2, 2'h2);
            8'h73: d = ent(bbd_pkg::CL_IND_JUMP, 2'h1, 2'h2); // RULE_07
            8'h60: d = ent(bbd_pkg::CL_BR_ACC_Z, 2'h2, 2'h2);
            8'h70: d = ent(bbd_pkg::CL_BR_ACC_NZ, 2'h2, 2'h2); // RULE_08
            8'h40: d = ent(bbd_pkg::CL_BR_C1, 2'h2, 2'h2); // RULE_09
            8'h50: d = ent(bbd_pkg::CL_BR_C0, 2'h2, 2'h2); // RULE_10
            8'h20: d = ent(bbd_pkg::CL_BR_BIT1, 2'h3, 2'h2); // RULE_11
            8'h30: d = ent(bbd_pkg::CL_BR_BIT0, 2'h3, 2'h2); // RULE_12
            8'h10: d = ent(bbd_pkg::CL_BR_BIT1_CLR, 2'h3, 2'h2); // RULE_13
            8'hB5: d = ent(bbd_pkg::CL_CMP_DIR, 2'h3, 2'h2); // RULE_14
            8'hB4: d = ent(bbd_pkg::CL_CMP_IMM, 2'h3, 2'h2); // RULE_15
            8'hD5: d = ent(bbd_pkg::CL_DEC_DIR, 2'h3, 2'h2); // RULE_19
            default: begin
                if (i_opcode[3:0] == 4'h1) begin
                    d = ent(i_opcode[4] ? bbd_pkg::CL_SHORT_CALL : bbd_pkg::CL_SHORT_JUMP, 2'h2, 2'h2); // RULE_24
                end else if (i_opcode[7:3] == 5'h17) begin
                    d = ent(bbd_pkg::CL_CMP_REG, 2'h3, 2'h2); // RULE_16
                end else if (i_opcode[7:1] == 7'h5B) begin
                    d = ent(bbd_pkg::CL_CMP_IND, 2'h3, 2'h2); // RULE_17
                end else if (i_opcode[7:3] == 5'h1B) begin
                    d = ent(bbd_pkg::CL_DEC_REG, 2'h2, 2'h2); // RULE_18
                end
            end
        endcase
    end

    assign o_class = bbd_pkg::bbd_class_type'(d[9:4]);
    assign o_len = d[3:2];
    assign o_cycles = d[1:0];
endmodule // bbd_decode
`default_nettype wire

// ### sim/bbd_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Program memory that answers every fetch strobe in the same cycle.
module bbd_prog_mem (
    input wire logic [15:0] i_addr, // Fetch address.
    input wire logic i_rd, // Fetch strobe.
    output logic [7:0] o_data // Program byte.
);
    logic [7:0] mem [0:65535];
    // Outside a strobe the byte is inverted, so a late sample cannot match by luck.
    assign o_data = i_rd ? mem[i_addr] : ~mem[i_addr];
endmodule // bbd_prog_mem
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_acc = 8'h01;
    logic [15:0] i_data_pointer_16 = 16'h1000;
    logic [7:0] code;
    logic [15:0] caddr;
    logic crd, carry, retire, irq, unh;
    int n_irq = 0;
    int n_unh = 0;
    logic [15:0] pc;
    logic [18:0] q [$];
    logic [18:0] e;
    logic seen = 1'b0;
    int n_errors = 0;
    int total_checks = 0;
    int cnt = 0;
    int k;
    bbd_core bbd_core_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_code_data(code), .i_acc(i_acc),
        .i_data_pointer_16(i_data_pointer_16), .o_code_addr(caddr), .o_code_rd(crd), .o_pc(pc), .o_carry(carry),
        .o_retire(retire), .o_irq_return(irq), .o_unhandled(unh));
    bbd_prog_mem bbd_prog_mem_inst (.i_addr(caddr), .i_rd(crd), .o_data(code));
    initial begin
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    task automatic ld(input logic [15:0] a, input logic [23:0] b, input int n);
        for (int i = 0; i < n; i++) bbd_prog_mem_inst.mem[a + 16'(i)] = b[8 * (n - 1 - i) +: 8];
    endtask
    task automatic note(input logic [15:0] p, input logic c, input logic [1:0] n);
        q.push_back({p, c, n});
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // Driver: loads the program and notes each retirement it expects.
    initial begin
        void'($urandom(32'hff91));
        for (k = 0; k < 65536; k++) bbd_prog_mem_inst.mem[k] = 8'h00;
        @(posedge i_ref_clk);
        i_acc <= 8'($urandom) | 8'h01;
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        // Reset leaves the data memory as it was, so the registers and bytes the compares read are preset.
        bbd_core_inst.u_ram.mem[8'h01] = 8'h30;
        bbd_core_inst.u_ram.mem[8'h03] = 8'h02;
        bbd_core_inst.u_ram.mem[8'h30] = 8'h55;
        bbd_core_inst.u_ram.mem[8'h40] = i_acc;
        ld(16'h0000, 24'h00_00d3, 1); note(16'h0001, 1'b1, 2'h1);
        ld(16'h0001, 24'h00_4002, 2); note(16'h0005, 1'b1, 2'h2);
        ld(16'h0005, 24'h00_00b3, 1); note(16'h0006, 1'b0, 2'h1);
        ld(16'h0006, 24'h00_5001, 2); note(16'h0009, 1'b0, 2'h2);
        ld(16'h0009, 24'h00_7001, 2); note(16'h000c, 1'b0, 2'h2);
        ld(16'h000c, 24'h00_d200, 2); note(16'h000e, 1'b0, 2'h1);
        ld(16'h000e, 24'h00_7200, 2); note(16'h0010, 1'b1, 2'h2);
        ld(16'h0010, 24'h00_b000, 2); note(16'h0012, 1'b0, 2'h2);
        ld(16'h0012, 24'h00_a000, 2); note(16'h0014, 1'b0, 2'h2);
        ld(16'h0014, 24'h00_a200, 2); note(16'h0016, 1'b1, 2'h1);
        ld(16'h0016, 24'h00_8200, 2); note(16'h0018, 1'b1, 2'h2);
        ld(16'h0018, 24'h10_0003, 3); note(16'h001e, 1'b1, 2'h2);
        ld(16'h001e, 24'h20_00fd, 3); note(16'h0021, 1'b1, 2'h2);
        ld(16'h0021, 24'h30_0080, 3); note(16'hffa4, 1'b1, 2'h2);
        ld(16'hffa4, 24'h02_0800, 3); note(16'h0800, 1'b1, 2'h2);
        ld(16'h0800, 24'h00_3110, 2); note(16'h0910, 1'b1, 2'h2);
        ld(16'h0910, 24'h00_0022, 1); note(16'h0802, 1'b1, 2'h2);
        ld(16'h0802, {8'hb4, i_acc ^ 8'h01, 8'h01}, 3); note(16'h0806, 1'b1, 2'h2);
        ld(16'h0806, 24'h00_9207, 2); note(16'h0808, 1'b1, 2'h2);
        ld(16'h0808, 24'h20_0702, 3); note(16'h080d, 1'b1, 2'h2);
        ld(16'h080d, 24'h00_00c3, 1); note(16'h080e, 1'b0, 2'h1);
        ld(16'h080e, 24'h00_b207, 2); note(16'h0810, 1'b0, 2'h1);
        ld(16'h0810, 24'h30_0701, 3); note(16'h0814, 1'b0, 2'h2);
        ld(16'h0814, 24'h00_db04, 2); note(16'h081a, 1'b0, 2'h2);
        ld(16'h081a, 24'hd5_0302, 3); note(16'h081d, 1'b0, 2'h2);
        ld(16'h081d, 24'hbb_0005, 3); note(16'h0820, 1'b0, 2'h2);
        ld(16'h0820, 24'hb7_5402, 3); note(16'h0825, 1'b0, 2'h2);
        ld(16'h0825, 24'hb5_40fe, 3); note(16'h0828, 1'b0, 2'h2);
        ld(16'h0828, 24'h00_60fe, 2); note(16'h082a, 1'b0, 2'h2);
        ld(16'h082a, 24'h00_8002, 2); note(16'h082e, 1'b0, 2'h2);
        ld(16'h082e, 24'h00_4140, 2); note(16'h0a40, 1'b0, 2'h2);
        ld(16'h0a40, 24'h00_1150, 2); note(16'h0850, 1'b0, 2'h2);
        ld(16'h0850, 24'h00_0004, 1); note(16'h0851, 1'b0, 2'h1);
        ld(16'h0851, 24'h00_0032, 1); note(16'h0a42, 1'b0, 2'h2);
        ld(16'h0a42, 24'h00_0073, 1); note(16'h1000 + {8'h00, i_acc}, 1'b0, 2'h2);
        note(16'h1001 + {8'h00, i_acc}, 1'b0, 2'h1);
        k = 0;
        while (q.size() != 0 && k < 4000) begin
            @(posedge i_ref_clk);
            k++;
        end
        `CHK(q.size(), 0)
        `CHK(n_irq, 1)
        `CHK(n_unh, 1)
        give_verdict();
    end
    // ==========================================================
    // Monitor: each retirement takes the oldest note and checks pc and carry, and the spacing from the second retirement on.
    always @(posedge i_ref_clk) begin
        cnt <= cnt + 1;
        if (!i_rst && irq === 1'b1) n_irq <= n_irq + 1;
        if (!i_rst && unh === 1'b1) n_unh <= n_unh + 1;
        if (!i_rst && retire === 1'b1 && q.size() != 0) begin
            e = q.pop_front();
            `CHK({pc, carry}, e[18:2])
            if (seen) `CHK(cnt, 16 * int'(e[1:0]))
            seen <= 1'b1;
            cnt <= 1;
        end
    end
    initial begin
        repeat (6000) @(posedge i_ref_clk);
        n_errors++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
